// >>> logic/mfm_core.sv
module mfm_core #(
    parameter mfm_pkg::mfm_variant_t VARIANT = mfm_pkg::MFM_LARGE
) (
    // clock and reset
    input  wire logic                   i_clock,
    input  wire logic                   i_rst_n,
    // oscillator mode
    input  wire logic                   i_rc_mode,
    // program memory
    output logic [mfm_pkg::PC_W-1:0]    o_prog_addr,
    input  wire logic [11:0]            i_prog_word,
    // data register file
    output mfm_pkg::mfm_file_bus_t      o_file,
    input  wire logic [7:0]             i_file_rdata,
    // configuration and status
    output logic [2:0][7:0]             o_pin_direction,
    output logic [5:0]                  o_prescale_config,
    output logic                        o_cycle_clock,
    output mfm_pkg::mfm_phase_t         o_phase,
    output logic [11:0]                 o_exec_word,
    output logic [7:0]                  o_work,
    output logic [7:0]                  o_flags,
    output logic [7:0]                  o_pointer
);
    import mfm_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    localparam logic [10:0] PC_MASK =
        (VARIANT == MFM_SMALL) ? PC_MASK_SMALL : PC_MASK_LARGE;
    localparam logic [10:0] RESET_VEC =
        (VARIANT == MFM_SMALL) ? RESET_VEC_SMALL : RESET_VEC_LARGE;

    mfm_state_t state_reg;
    mfm_state_t state_next;

    ////////////////////////////////////////////////////////////////////////
    // physical file address; indirect when the field is zero
    function automatic logic [7:0] eff_addr(input logic [4:0] f,
                                            input logic [7:0] ptr);
        logic [7:0] src;
        logic [2:0] bank;
        src  = (f == ADDR_INDIRECT) ? ptr : {ptr[7:5], f};
        bank = 3'h0;
        if (VARIANT == MFM_MIDDLE) begin
            bank = src[7:5] & BANK_MASK_MIDDLE;
        end else if (VARIANT == MFM_LARGE) begin
            bank = src[7:5] & BANK_MASK_LARGE;
        end
        // low half of each bank holds the specials, shared by all banks
        if (!src[4]) begin
            bank = 3'h0;
        end
        eff_addr = {bank, src[4:0]};
    endfunction

    // core-held locations never go out on the file bus
    function automatic logic is_internal(input logic [7:0] a);
        is_internal = (a == {3'h0, ADDR_INDIRECT}) || (a == {3'h0, ADDR_PC_LOW})
                   || (a == {3'h0, ADDR_FLAGS}) || (a == {3'h0, ADDR_POINTER});
    endfunction

    function automatic logic is_port(input logic [7:0] a);
        unique case (a)
            {3'h0, ADDR_IO_A}, {3'h0, ADDR_IO_B}: is_port = 1'b1;
            {3'h0, ADDR_IO_C}: is_port = (VARIANT != MFM_SMALL);
            {3'h0, ADDR_IO_D}, {3'h0, ADDR_IO_E}:
                is_port = (VARIANT == MFM_LARGE);
            default: is_port = 1'b0;
        endcase
    endfunction

    function automatic logic reads_file(input logic [11:0] wd);
        reads_file = (wd[11:6] == OP_MOVF);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [7:0]  cur_addr;
    logic [7:0]  new_addr;
    logic [11:0] new_word;
    logic [7:0]  read_val;
    logic [7:0]  result;
    logic        dest_file;
    logic        is_movf;
    logic [1:0]  page;
    logic [10:0] pc_inc;

    always_comb begin
        state_next = state_reg;
        is_movf    = (state_reg.exec_word[11:6] == OP_MOVF);
        cur_addr   = eff_addr(state_reg.exec_word[4:0], state_reg.pointer);
        new_word   = state_reg.flush ? OP_IDLE : state_reg.fetch_word;
        new_addr   = eff_addr(new_word[4:0], state_reg.pointer);
        page       = (VARIANT == MFM_SMALL) ? 2'h0
                   : state_reg.flags[PAGE_POS +: 2];
        pc_inc     = (state_reg.pc + 11'h001) & PC_MASK;
        result     = is_movf ? state_reg.operand : state_reg.w;
        dest_file  = (state_reg.exec_word[11:5] == OP_MOVWF)
                  || (is_movf && state_reg.exec_word[5]);

        // operand source: core registers or the external file
        read_val = i_file_rdata;
        if (cur_addr == {3'h0, ADDR_INDIRECT}) begin
            read_val = 8'h00;
        end else if (cur_addr == {3'h0, ADDR_PC_LOW}) begin
            read_val = state_reg.pc[7:0];
        end else if (cur_addr == {3'h0, ADDR_FLAGS}) begin
            read_val = state_reg.flags;
        end else if (cur_addr == {3'h0, ADDR_POINTER}) begin
            read_val = state_reg.pointer;
        end else if (cur_addr == {3'h0, ADDR_IO_A}) begin
            read_val = i_file_rdata & IO_A_READ_MASK;
        end else if (cur_addr == {3'h0, ADDR_IO_E} && is_port(cur_addr)) begin
            read_val = i_file_rdata & IO_E_READ_MASK;
        end

        // with i_rc_mode set, cycle clock high through the second half of each cycle
        state_next.cycle_clk = i_rc_mode
            && (state_reg.phase == PHASE_TWO || state_reg.phase == PHASE_THREE);

        unique case (state_reg.phase)
            PHASE_ONE: begin
                state_next.phase      = PHASE_TWO;
                state_next.fetch_addr = state_reg.pc;
                state_next.pc         = pc_inc;
                state_next.exec_word  = new_word;
                state_next.flush      = 1'b0;
                state_next.file.addr  = new_addr;
                state_next.file.port  = is_port(new_addr);
                state_next.file.rd    = reads_file(new_word)
                                     && !is_internal(new_addr);
            end
            PHASE_TWO: begin
                state_next.phase   = PHASE_THREE;
                state_next.operand = read_val;
                state_next.file.rd = 1'b0;
            end
            PHASE_THREE: begin
                state_next.phase      = PHASE_FOUR;
                state_next.file.wdata = result;
                state_next.file.wr    = dest_file && !is_internal(cur_addr);
            end
            PHASE_FOUR: begin
                state_next.phase      = PHASE_ONE;
                state_next.file.wr    = 1'b0;
                state_next.fetch_word = i_prog_word;
                if (dest_file) begin
                    if (cur_addr == {3'h0, ADDR_PC_LOW}) begin
                        // computed jump: bit 8 cleared, pipeline refilled
                        state_next.pc    = {page, 1'b0, result} & PC_MASK;
                        state_next.flush = 1'b1;
                    end else if (cur_addr == {3'h0, ADDR_FLAGS}) begin
                        state_next.flags = (state_reg.flags & ~FLAGS_WR_MASK)
                                         | (result & FLAGS_WR_MASK);
                    end else if (cur_addr == {3'h0, ADDR_POINTER}) begin
                        state_next.pointer = result;
                    end
                end
                if (is_movf) begin
                    // zero flag from logic wins over a direct flags write
                    state_next.flags[FLAGS_ZERO_POS] = (result == 8'h00);
                    if (!state_reg.exec_word[5]) begin
                        state_next.w = result;
                    end
                end
                if (state_reg.exec_word == OP_OPTION) begin
                    state_next.prescale = state_reg.w[5:0];
                end
                if (state_reg.exec_word[11:3] == OP_DIR_SET
                    && state_reg.exec_word[2:0] >= ADDR_IO_A[2:0]) begin
                    state_next.direction[state_reg.exec_word[2:0]
                                         - ADDR_IO_A[2:0]] = state_reg.w;
                end
                if (state_reg.exec_word[11:8] == OP_MOVLW) begin
                    state_next.w = state_reg.exec_word[7:0];
                end
                if (state_reg.exec_word[11:9] == OP_JUMP) begin
                    state_next.pc = {page, state_reg.exec_word[8:0]}
                                  & PC_MASK;
                    state_next.flush = 1'b1;
                end
                if (state_reg.exec_word[11:8] == OP_CALL) begin
                    state_next.pc = {page, 1'b0, state_reg.exec_word[7:0]}
                                  & PC_MASK;
                    state_next.flush = 1'b1;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            state_reg            <= '0;
            state_reg.phase      <= PHASE_ONE;
            // first fetch is at the reset vector, nothing yet to execute
            state_reg.pc         <= RESET_VEC & PC_RESET;
            state_reg.fetch_word <= OP_IDLE;
            state_reg.exec_word  <= OP_IDLE;
            state_reg.flush      <= 1'b1;
            state_reg.flags      <= FLAGS_RESET;
            state_reg.pointer    <= POINTER_RESET;
            state_reg.direction  <= {DIR_COUNT{DIR_RESET}};
            state_reg.prescale   <= PRESCALE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign o_prog_addr       = state_reg.fetch_addr;
    assign o_file            = state_reg.file;
    assign o_pin_direction   = state_reg.direction;
    assign o_prescale_config = state_reg.prescale;
    assign o_cycle_clock     = state_reg.cycle_clk;
    assign o_phase           = state_reg.phase;
    assign o_exec_word       = state_reg.exec_word;
    assign o_work            = state_reg.w;
    assign o_flags           = state_reg.flags;
    assign o_pointer         = state_reg.pointer;

endmodule

// >>> logic/mfm_pkg.sv
package mfm_pkg;

    typedef enum logic [1:0] {MFM_SMALL, MFM_MIDDLE, MFM_LARGE} mfm_variant_t;
    typedef enum logic [1:0] {PHASE_ONE, PHASE_TWO, PHASE_THREE, PHASE_FOUR} mfm_phase_t;

    ////////////////////////////////////////////////////////////////////////
    localparam int PC_W                  = 11;
    localparam logic [10:0] PC_MASK_SMALL = 11'h1FF;
    localparam logic [10:0] PC_MASK_LARGE = 11'h7FF;
    localparam logic [10:0] RESET_VEC_SMALL = 11'h1FF;
    localparam logic [10:0] RESET_VEC_LARGE = 11'h7FF;
    localparam int PAGE_POS              = 5;
    localparam logic [2:0] BANK_MASK_MIDDLE = 3'h3;
    localparam logic [2:0] BANK_MASK_LARGE  = 3'h7;

    ////////////////////////////////////////////////////////////////////////
    localparam logic [4:0] ADDR_INDIRECT = 5'h00;
    localparam logic [4:0] ADDR_TIMER    = 5'h01;
    localparam logic [4:0] ADDR_PC_LOW   = 5'h02;
    localparam logic [4:0] ADDR_FLAGS    = 5'h03;
    localparam logic [4:0] ADDR_POINTER  = 5'h04;
    localparam logic [4:0] ADDR_IO_A     = 5'h05;
    localparam logic [4:0] ADDR_IO_B     = 5'h06;
    localparam logic [4:0] ADDR_IO_C     = 5'h07;
    localparam logic [4:0] ADDR_IO_D     = 5'h08;
    localparam logic [4:0] ADDR_IO_E     = 5'h09;
    localparam logic [7:0] IO_A_READ_MASK = 8'h0F;
    localparam logic [7:0] IO_E_READ_MASK = 8'hF0;

    ////////////////////////////////////////////////////////////////////////
    localparam logic [10:0] PC_RESET       = 11'h7FF;
    localparam logic [7:0]  FLAGS_RESET    = 8'h18;
    localparam logic [7:0]  FLAGS_WR_MASK  = 8'hE7;
    localparam int          FLAGS_ZERO_POS = 2;
    localparam logic [7:0]  POINTER_RESET  = 8'h00;
    localparam logic [7:0]  DIR_RESET      = 8'hFF;
    localparam logic [5:0]  PRESCALE_RESET = 6'h3F;
    localparam int          DIR_COUNT      = 3;

    ////////////////////////////////////////////////////////////////////////
    localparam logic [11:0] OP_IDLE    = 12'h000;
    localparam logic [11:0] OP_OPTION  = 12'h002;
    localparam logic [8:0]  OP_DIR_SET = 9'h000;
    localparam logic [6:0]  OP_MOVWF   = 7'h01;
    localparam logic [5:0]  OP_MOVF    = 6'h08;
    localparam logic [2:0]  OP_JUMP    = 3'h5;
    localparam logic [3:0]  OP_CALL    = 4'h9;
    localparam logic [3:0]  OP_MOVLW   = 4'hC;

    typedef struct packed {
        logic [7:0] addr;
        logic       rd;
        logic       wr;
        logic [7:0] wdata;
        logic       port;
    } mfm_file_bus_t;

    typedef struct packed {
        mfm_phase_t           phase;
        logic [10:0]          pc;
        logic [10:0]          fetch_addr;
        logic [11:0]          fetch_word;
        logic [11:0]          exec_word;
        logic                 flush;
        logic [7:0]           w;
        logic [7:0]           operand;
        logic [7:0]           flags;
        logic [7:0]           pointer;
        logic [2:0][7:0]      direction;
        logic [5:0]           prescale;
        logic                 cycle_clk;
        mfm_file_bus_t        file;
    } mfm_state_t;

endpackage

// >>> verification/mfm_chk.sv
module mfm_chk (
    // clock, reset and oscillator mode
    input  wire logic                      i_clock,
    input  wire logic                      i_rst_n,
    input  wire logic                      i_rc_mode,
    // observed outputs
    input  wire logic [mfm_pkg::PC_W-1:0]  o_prog_addr,
    input  wire mfm_pkg::mfm_file_bus_t    o_file,
    input  wire logic [2:0][7:0]           o_pin_direction,
    input  wire logic [5:0]                o_prescale_config,
    input  wire logic                      o_cycle_clock,
    input  wire mfm_pkg::mfm_phase_t       o_phase,
    input  wire logic [11:0]               o_exec_word
);
    timeunit 1ns;
    timeprecision 1ps;
    import mfm_pkg::*;

    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    ////////////////////////////////////////////////////////////////////////
    phase_order_a: assert property ($past(i_rst_n) |-> 2'(o_phase - $past(o_phase)) == 2'h1)
        else $error("phase did not step in order");
    cycle_clock_a: assert property ($past(i_rst_n)
        |-> o_cycle_clock == ($past(i_rc_mode) && o_phase inside {PHASE_THREE, PHASE_FOUR}))
        else $error("cycle clock off its phases");
    fetch_hold_a: assert property ($past(i_rst_n) && o_phase != PHASE_TWO |-> $stable(o_prog_addr))
        else $error("fetch address moved mid cycle");
    read_phase_a: assert property (o_file.rd |-> o_phase == PHASE_TWO)
        else $error("operand read outside phase two");
    write_phase_a: assert property (o_file.wr |-> o_phase == PHASE_FOUR ##1 !o_file.wr)
        else $error("destination write outside phase four");
    bank_alias_a: assert property ((o_file.rd || o_file.wr) && !o_file.addr[4]
        |-> o_file.addr[7:5] == 3'h0) else $error("low region not folded to bank zero");
    core_hidden_a: assert property ((o_file.rd || o_file.wr)
        |-> !(o_file.addr[4:0] inside {5'h00, 5'h02, 5'h03, 5'h04})) else $error("core register on file bus");
    port_flag_a: assert property ((o_file.rd || o_file.wr) && o_file.port
        |-> o_file.addr inside {8'h05, 8'h06, 8'h07, 8'h08, 8'h09}) else $error("port flag on a general register");
    dir_source_a: assert property ($past(i_rst_n) && !$stable(o_pin_direction)
        |-> $past(o_exec_word) inside {12'h005, 12'h006, 12'h007}) else $error("direction changed without opcode");
    option_source_a: assert property ($past(i_rst_n) && !$stable(o_prescale_config)
        |-> $past(o_exec_word) == OP_OPTION) else $error("prescaler changed without opcode");

    cover property (o_file.rd);
    cover property (o_file.wr);
    cover property ($rose(o_cycle_clock));
    cover property (o_file.rd && o_file.port);
endmodule

bind mfm_core mfm_chk u_chk (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_rc_mode(i_rc_mode), .o_prog_addr(o_prog_addr), .o_file(o_file),
    .o_pin_direction(o_pin_direction), .o_prescale_config(o_prescale_config), .o_cycle_clock(o_cycle_clock),
    .o_phase(o_phase), .o_exec_word(o_exec_word));

// >>> verification/mfm_mem_model.sv
module mfm_mem_model (
    // clock
    input  wire logic                   i_clock,
    // program side
    input  wire logic [10:0]            i_prog_addr,
    output logic      [11:0]            o_prog_word,
    // register file side
    input  wire mfm_pkg::mfm_file_bus_t i_file,
    output logic      [7:0]             o_file_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import mfm_pkg::*;

    logic [11:0] prog[2048];
    logic [7:0]  regs[256];

    ////////////////////////////////////////////////////////////////////////
    // word answers at once, the core only samples it at phase four
    assign o_prog_word = prog[i_prog_addr];
    // no read strobe: inverted data, so a stale sample cannot pass by luck
    assign o_file_rdata = i_file.rd ? regs[i_file.addr] : ~regs[i_file.addr];

    always @(posedge i_clock) begin
        if (i_file.wr) begin
            regs[i_file.addr] <= i_file.wdata;
        end
    end
endmodule

// >>> verification/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import mfm_pkg::*;

    logic            i_clock = 1'b0;
    logic            i_rst_n = 1'b0;
    logic            rc_mode = 1'b1;
    logic [10:0]     prog_addr;
    logic [11:0]     prog_word;
    mfm_file_bus_t   file_bus;
    logic [7:0]      file_rdata;
    logic [2:0][7:0] pin_dir;
    logic [5:0]      prescale;
    mfm_phase_t      phase;
    logic [7:0]      work;
    logic [7:0]      flags;
    logic [7:0]      pointer;
    logic [10:0]     fetched[$];
    int              err_count = 0;
    int              n_checks = 0;
    int              t;
    // {address, word}; words in flushed slots are writes that must never land
    logic [22:0]     image[27] = '{
        {11'h7FF, 12'h000}, {11'h000, 12'hC3C}, {11'h001, 12'h030}, {11'h002, 12'hC5C}, {11'h003, 12'h024},
        {11'h004, 12'h020}, {11'h005, 12'h002}, {11'h006, 12'h006}, {11'h007, 12'h210}, {11'h008, 12'h031},
        {11'h009, 12'hA0C}, {11'h00A, 12'h032}, {11'h00B, 12'h033}, {11'h00C, 12'hBF0}, {11'h00D, 12'h034},
        {11'h1F0, 12'h022}, {11'h1F1, 12'h034}, {11'h03C, 12'h035}, {11'h03D, 12'hC20}, {11'h03E, 12'h023},
        {11'h03F, 12'hA40}, {11'h040, 12'h034}, {11'h240, 12'h036}, {11'h241, 12'h205}, {11'h242, 12'h037},
        {11'h243, 12'hA43}, {11'h244, 12'h034}};
    logic [10:0]     tail[15] = '{11'h00C, 11'h00D, 11'h1F0, 11'h1F1, 11'h03C, 11'h03D, 11'h03E, 11'h03F,
                                  11'h040, 11'h240, 11'h241, 11'h242, 11'h243, 11'h244, 11'h243};

    always #2 i_clock = ~i_clock;

    mfm_core uut (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_rc_mode(rc_mode), .o_prog_addr(prog_addr),
        .i_prog_word(prog_word), .o_file(file_bus), .i_file_rdata(file_rdata), .o_pin_direction(pin_dir),
        .o_prescale_config(prescale),
        .o_cycle_clock(), .o_phase(phase), .o_exec_word(), .o_work(work), .o_flags(flags), .o_pointer(pointer));

    mfm_mem_model pm (
        .i_clock(i_clock), .i_prog_addr(prog_addr), .o_prog_word(prog_word), .i_file(file_bus),
        .o_file_rdata(file_rdata));

    ////////////////////////////////////////////////////////////////////////
    // sampled in phase three, well after the phase-one edge has moved it
    always @(posedge i_clock) begin
        if (i_rst_n && phase == PHASE_THREE) begin
            fetched.push_back(prog_addr);
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        if (err_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        for (t = 0; t < 2048; t++) begin
            pm.prog[t] = 12'h000;
        end
        for (t = 0; t < 256; t++) begin
            pm.regs[t] = 8'hA5;
        end
        pm.regs[8'h05] = 8'hFF;
        pm.regs[8'h50] = 8'h3C;
        for (t = 0; t < 27; t++) begin
            pm.prog[image[t][22:12]] = image[t][11:0];
        end
        // second pass repeats everything after a reset in mid-run, cycle clock output off
        for (int p = 0; p < 2; p++) begin
            @(posedge i_clock);
            i_rst_n <= 1'b0;
            rc_mode <= (p == 0);
            repeat (20) @(posedge i_clock);
            #1;
            check({pin_dir, 2'b00, prescale}, 32'hFFFFFF3F);
            check({flags, pointer, work}, 24'h180000);
            fetched.delete();
            @(posedge i_clock) i_rst_n <= 1'b1;
            for (t = 0; t < 400 && fetched.size() < 27; t++) begin
                @(posedge i_clock);
            end
            if (fetched.size() < 27) begin
                err_count++;
                final_report();
            end
            check(fetched[0], 11'h7FF);
            for (int k = 1; k < 12; k++) begin
                check(fetched[k], 11'(k - 1));
            end
            for (int k = 0; k < 15; k++) begin
                check(fetched[12 + k], tail[k]);
            end
        end
        check(pm.regs[8'h10], 8'h3C);
        check(pm.regs[8'h5C], 8'h5C);
        check(pm.regs[8'h51], 8'h3C);
        check({pm.regs[8'h52], pm.regs[8'h53], pm.regs[8'h54]}, 24'hA5A5A5);
        check(pm.regs[8'h55], 8'h3C);
        check(pm.regs[8'h56], 8'h20);
        check(pm.regs[8'h57], 8'h0F);
        check({pin_dir, 2'b00, prescale}, 32'hFF5CFF1C);
        check({flags, pointer, work}, 24'h385C0F);
        final_report();
    end
endmodule
